// ---- core/lbir_pkg.sv ----
package lbir_pkg;
  localparam int REG_W = 8;
  localparam int IDX_W = 6;
  localparam int N_TRIB = 16;
  localparam int N_MUX = 4;
  localparam int TRIB_PER_MUX = 4;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_IND = 6'h07;
  localparam logic [IDX_W-1:0] IDX_TRIB_LO = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_TRIB_HI = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_LOW_LOOP = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_HI_LOOP = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_LINE_LOOP = 6'h10;
  localparam logic [IDX_W-1:0] IDX_LO_BER = 6'h11;
  localparam logic [IDX_W-1:0] IDX_HI_BER = 6'h12;
  localparam logic [IDX_W-1:0] IDX_IND_MASK = 6'h13;
  localparam logic [IDX_W-1:0] IDX_LOS_MASK_LO = 6'h14;
  localparam logic [IDX_W-1:0] IDX_LOS_MASK_HI = 6'h15;
  localparam logic [IDX_W-1:0] IDX_ALM_MASK = 6'h16;
  // Reset values
  localparam logic [REG_W-1:0] RST_ZERO = 8'h00;
  localparam logic [REG_W-1:0] RST_LO_BER = 8'h63;
  localparam logic [REG_W-1:0] RST_HI_BER = 8'hDF;
  // Indication register fields
  localparam int IND_SUM = 7;
  localparam int IND_LINE = 6;
  localparam int IND_DEMUX_LSB = 2;
  localparam int IND_TRIB_HI = 1;
  localparam int IND_TRIB_LO = 0;
  // Loop control fields
  localparam int LOW_LL_LSB = 4;
  localparam int LOW_RL_LSB = 0;
  localparam int LINE_RL_BIT = 1;
  localparam int LINE_LL_BIT = 0;
  // Alarm mask field: bits 3-0 demux alarms, bit 4 line alarm
  localparam int AMSK_LINE_BIT = 4;
endpackage

// ---- core/lbir_regs.sv ----
`timescale 1ns/1ps
// What this block does
// R1: Set bit loops E1 channel 1-8 receive to transmit, AIS toward mux.
// R2: Same E1 remote loopback for channels 9-16, top bit is channel 16.
// R3: Local loop returns E2 transmit as receive, AIS upstream, drops rx.
// R4: Local loop bits act in both mux modes, top bit is block 4.
// R5: Remote loop returns E2 rx clock/data as tx, AIS to its E1 outputs.
// R6: E2 remote loop feeds demuxed E2 back into E3 mux, AIS downstream.
// R7: Board supplies dejittered demux clock on the E2 receive clock input.
// R8: E3 remote loop returns line rx to tx, AIS to demux, mux dropped.
// R9: E3 local loop feeds mux output back to demux, AIS to line.
// R10: Shared E2 BER threshold resets to 63H, drives all four demuxes.
// R11: E3 BER threshold resets to DFH.
// R12: Writing one clears an indication bit; zero keeps; reset clears.
// R13: Unmasked alarm change either way latches its indication bit.
// R14: Indication bit 7 reads one while any of bits 6-0 is set.
// R15: Indication bit 6 flags an unmasked E3 alarm.
// R16: Indication bits 5-2 flag E2 alarms of demuxes 4-1.
// R17: Bit 1 flags E1 loss on channels 9-16, bit 0 on 1-8.
// R18: Alarm mask bit blocks indication and interrupt; masks reset zero.
// R19: Interrupt output high while an unmasked indication stays latched.
module lbir_regs
  import lbir_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Alarm levels from detectors
  input wire logic [N_TRIB-1:0] tributary_signal_loss_flag,
  input wire logic [N_MUX-1:0] demux_alarm,
  input wire logic line_alarm,
  // Tributary streams
  input wire logic [N_TRIB-1:0] trib_line_rx_d,
  input wire logic [N_TRIB-1:0] trib_drop_d,
  output logic [N_TRIB-1:0] trib_line_tx_d,
  output logic [N_TRIB-1:0] trib_add_d,
  // Low mux second-order side
  input wire logic [N_MUX-1:0] low_mux_tx_d,
  input wire logic [N_MUX-1:0] low_mux_tx_clk,
  input wire logic [N_MUX-1:0] low_rx_d,
  input wire logic [N_MUX-1:0] low_rx_clk,
  output logic [N_MUX-1:0] low_tx_d,
  output logic [N_MUX-1:0] low_tx_clk,
  output logic [N_MUX-1:0] low_demux_d,
  // High mux second-order side
  input wire logic [N_MUX-1:0] hi_demux_d,
  input wire logic [N_MUX-1:0] hi_demux_clk,
  input wire logic [N_MUX-1:0] demux_receive_clock_in,
  input wire logic [N_MUX-1:0] hi_tx_d,
  input wire logic [N_MUX-1:0] hi_tx_clk,
  output logic [N_MUX-1:0] hi_mux_d,
  output logic [N_MUX-1:0] hi_mux_clk,
  output logic [N_MUX-1:0] hi_rx_d,
  output logic [N_MUX-1:0] demux_gapped_clock_out,
  // Third-order line side
  input wire logic line_rx_d,
  input wire logic line_rx_clk,
  input wire logic e3_mux_d,
  input wire logic e3_mux_clk,
  output logic line_tx_d,
  output logic line_tx_clk,
  output logic e3_demux_d,
  output logic e3_demux_clk,
  // BER thresholds
  output logic [REG_W-1:0] low_ber_threshold,
  output logic [REG_W-1:0] hi_ber_threshold
);

  logic [REG_W-1:0] trib_lo_q, trib_hi_q, low_loop_q, hi_loop_q;
  logic [REG_W-1:0] line_loop_q, lo_ber_q, hi_ber_q;
  logic [REG_W-1:0] ind_mask_q, los_mask_lo_q, los_mask_hi_q, alm_mask_q;
  logic [IND_SUM-1:0] ind_q, ind_d, ind_set, ind_clr;
  logic [N_TRIB-1:0] los_prev_q, los_chg, trib_loop, trib_term;
  logic [N_MUX-1:0] dmx_prev_q, dmx_chg, low_ll, low_rl, hi_rl;
  logic line_prev_q, line_chg, line_rl, line_ll;
  logic [31:0] prdata_q;
  logic [REG_W-1:0] rd_val;
  logic [IDX_W-1:0] idx;
  logic hit, access, wr_en, rd_cap;

  // APB decode; a zero-wait slave, frozen by the clock enable
  assign idx = paddr[IDX_W+1:2];
  assign access = psel && penable;
  always_comb
  begin
    // Shift, not part-select: legal even with no spare address bits
    hit = (paddr[1:0] == 2'b00) && ((paddr >> (IDX_W + 2)) == '0);
    unique case (idx)
      IDX_IND: rd_val = {|ind_q, ind_q}; // see R14
      IDX_TRIB_LO: rd_val = trib_lo_q;
      IDX_TRIB_HI: rd_val = trib_hi_q;
      IDX_LOW_LOOP: rd_val = low_loop_q;
      IDX_HI_LOOP: rd_val = hi_loop_q;
      IDX_LINE_LOOP: rd_val = line_loop_q;
      IDX_LO_BER: rd_val = lo_ber_q;
      IDX_HI_BER: rd_val = hi_ber_q;
      IDX_IND_MASK: rd_val = ind_mask_q;
      IDX_LOS_MASK_LO: rd_val = los_mask_lo_q;
      IDX_LOS_MASK_HI: rd_val = los_mask_hi_q;
      IDX_ALM_MASK: rd_val = alm_mask_q;
      default:
      begin
        rd_val = RST_ZERO;
        hit = 1'b0;
      end
    endcase
  end

  assign wr_en = ce && access && pwrite && hit;
  assign rd_cap = ce && psel && !penable && !pwrite;
  assign pready = ce;
  assign pslverr = access && !hit;
  assign prdata = prdata_q;

  // Read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata_q <= '0;
    else if (rd_cap)
      prdata_q <= {24'h000000, rd_val};

  // Control registers; unused upper bits are held at zero
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      trib_lo_q <= RST_ZERO;
      trib_hi_q <= RST_ZERO;
      low_loop_q <= RST_ZERO;
      hi_loop_q <= RST_ZERO;
      line_loop_q <= RST_ZERO;
      lo_ber_q <= RST_LO_BER; // see R10
      hi_ber_q <= RST_HI_BER; // see R11
    end
    else if (wr_en)
    begin
      unique case (idx)
        IDX_TRIB_LO: trib_lo_q <= pwdata[7:0];
        IDX_TRIB_HI: trib_hi_q <= pwdata[7:0];
        IDX_LOW_LOOP: low_loop_q <= pwdata[7:0];
        IDX_HI_LOOP: hi_loop_q <= {4'h0, pwdata[3:0]};
        IDX_LINE_LOOP: line_loop_q <= {6'h00, pwdata[1:0]};
        IDX_LO_BER: lo_ber_q <= pwdata[7:0];
        IDX_HI_BER: hi_ber_q <= pwdata[7:0];
        default: ;
      endcase
    end

  // Mask registers
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ind_mask_q <= RST_ZERO;
      los_mask_lo_q <= RST_ZERO; // see R18
      los_mask_hi_q <= RST_ZERO;
      alm_mask_q <= RST_ZERO;
    end
    else if (wr_en)
    begin
      unique case (idx)
        IDX_IND_MASK: ind_mask_q <= {1'b0, pwdata[6:0]};
        IDX_LOS_MASK_LO: los_mask_lo_q <= pwdata[7:0];
        IDX_LOS_MASK_HI: los_mask_hi_q <= pwdata[7:0];
        IDX_ALM_MASK: alm_mask_q <= {3'h0, pwdata[4:0]};
        default: ;
      endcase
    end

  assign low_ber_threshold = lo_ber_q; // see R10
  assign hi_ber_threshold = hi_ber_q; // see R11

  // Alarm change detection; a toggle in either direction counts
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      los_prev_q <= '0;
      dmx_prev_q <= '0;
      line_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      los_prev_q <= tributary_signal_loss_flag;
      dmx_prev_q <= demux_alarm;
      line_prev_q <= line_alarm;
    end

  assign los_chg = (tributary_signal_loss_flag ^ los_prev_q)
    & ~{los_mask_hi_q, los_mask_lo_q}; // see R13, R18
  assign dmx_chg = (demux_alarm ^ dmx_prev_q) & ~alm_mask_q[N_MUX-1:0];
  assign line_chg = (line_alarm ^ line_prev_q) & ~alm_mask_q[AMSK_LINE_BIT];

  always_comb
  begin
    ind_set = '0;
    ind_set[IND_LINE] = line_chg; // see R15
    ind_set[IND_DEMUX_LSB +: N_MUX] = dmx_chg; // see R16
    ind_set[IND_TRIB_HI] = |los_chg[N_TRIB-1:8]; // see R17
    ind_set[IND_TRIB_LO] = |los_chg[7:0]; // see R17
    ind_clr = (wr_en && idx == IDX_IND) ? pwdata[6:0] : '0;
    // A new event in the clearing cycle survives the clear
    ind_d = (ind_q & ~ind_clr) | ind_set; // see R12, R13
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ind_q <= '0; // see R12
    else if (ce)
      ind_q <= ind_d;

  // Per-alarm masks already gate ind_set, so they also keep irq low
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq <= 1'b0;
    else if (ce)
      irq <= |(ind_d & ~ind_mask_q[IND_SUM-1:0]); // see R19

  // Loop control decode
  assign trib_loop = {trib_hi_q, trib_lo_q}; // see R1, R2
  assign low_ll = low_loop_q[LOW_LL_LSB +: N_MUX]; // see R4
  assign low_rl = low_loop_q[LOW_RL_LSB +: N_MUX];
  assign hi_rl = hi_loop_q[N_MUX-1:0];
  assign line_rl = line_loop_q[LINE_RL_BIT];
  assign line_ll = line_loop_q[LINE_LL_BIT];
  always_comb
  begin
    for (int i = 0; i < N_TRIB; i++)
      trib_term[i] = low_rl[i / TRIB_PER_MUX]; // see R5
  end

  // Tributary streams: loop wins over the AIS of a looped low mux
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      trib_line_tx_d <= '0;
      trib_add_d <= '0;
    end
    else if (ce)
    begin
      trib_line_tx_d <= (trib_loop & trib_line_rx_d)
        | (~trib_loop & (trib_term | trib_drop_d)); // see R1, R5
      trib_add_d <= trib_loop | trib_line_rx_d; // see R1, R2
    end

  // Low mux side; remote loop outranks local loop on the transmit pins
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      low_tx_d <= '0;
      low_tx_clk <= '0;
      low_demux_d <= '0;
    end
    else if (ce)
    begin
      low_tx_d <= (low_rl & low_rx_d)
        | (~low_rl & (low_ll | low_mux_tx_d)); // see R3, R5
      low_tx_clk <= (low_rl & low_rx_clk) | (~low_rl & low_mux_tx_clk);
      low_demux_d <= (low_ll & low_mux_tx_d) | (~low_ll & low_rx_d); // see R3
    end

  // High mux loop uses the dejittered clock: the mux cannot take gaps
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      hi_mux_d <= '0;
      hi_mux_clk <= '0;
      hi_rx_d <= '0;
      demux_gapped_clock_out <= '0;
    end
    else if (ce)
    begin
      hi_mux_d <= (hi_rl & hi_demux_d) | (~hi_rl & hi_tx_d); // see R6
      hi_mux_clk <= (hi_rl & demux_receive_clock_in)
        | (~hi_rl & hi_tx_clk); // see R7
      hi_rx_d <= hi_rl | hi_demux_d; // see R6
      demux_gapped_clock_out <= hi_demux_clk;
    end

  // Line side; with both loops set the remote loop owns both directions
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      line_tx_d <= 1'b0;
      line_tx_clk <= 1'b0;
      e3_demux_d <= 1'b0;
      e3_demux_clk <= 1'b0;
    end
    else if (ce)
    begin
      line_tx_d <= line_rl ? line_rx_d : (line_ll | e3_mux_d); // see R8, R9
      line_tx_clk <= line_rl ? line_rx_clk : e3_mux_clk;
      e3_demux_d <= line_rl | (line_ll ? e3_mux_d : line_rx_d); // see R8, R9
      e3_demux_clk <= line_ll && !line_rl ? e3_mux_clk : line_rx_clk;
    end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(logic [IDX_W-1:0] r);
    ce && access && pwrite && hit && idx == r;
  endsequence
  sequence s_rd_setup(logic [IDX_W-1:0] r);
    ce && psel && !penable && !pwrite && idx == r;
  endsequence
  a_trib_loop_ais: assert property ( // see R1
    ce |=> (trib_add_d & $past(trib_loop)) == $past(trib_loop))
    else $error("looped E1 channel not sending AIS toward mux");
  a_low_term_ais: assert property ( // see R5
    ce && low_rl[3] && trib_loop[15:12] == 4'h0
    |=> trib_line_tx_d[15:12] == 4'hF)
    else $error("terminated E1 channels of block 4 lack AIS");
  a_low_local_loop: assert property ( // see R3
    ce && low_ll[0] && !low_rl[0]
    |=> low_tx_d[0] && low_demux_d[0] == $past(low_mux_tx_d[0]))
    else $error("low mux local loop path wrong");
  a_hi_remote_loop: assert property ( // see R6
    ce && hi_rl[3] |=> hi_rx_d[3]
    && hi_mux_d[3] == $past(hi_demux_d[3])
    && hi_mux_clk[3] == $past(demux_receive_clock_in[3]))
    else $error("E2 remote loop path wrong");
  a_line_remote_loop: assert property ( // see R8
    ce && line_rl |=> e3_demux_d && line_tx_d == $past(line_rx_d))
    else $error("E3 remote loop path wrong");
  a_line_local_loop: assert property ( // see R9
    ce && line_ll && !line_rl
    |=> line_tx_d && e3_demux_d == $past(e3_mux_d))
    else $error("E3 local loop path wrong");
  a_ber_write: assert property ( // see R10
    s_wr(IDX_LO_BER) |=> low_ber_threshold == $past(pwdata[7:0]))
    else $error("E2 threshold did not take written value");
  a_ber3_write: assert property ( // see R11
    s_wr(IDX_HI_BER) |=> hi_ber_threshold == $past(pwdata[7:0]))
    else $error("E3 threshold did not take written value");
  a_ind_clear: assert property ( // see R12
    s_wr(IDX_IND) ##0 (pwdata[IND_LINE] && !line_chg) |=> !ind_q[IND_LINE])
    else $error("write one did not clear indication");
  a_ind_hold: assert property ( // see R12
    ce && ind_q[IND_TRIB_LO] && !(wr_en && idx == IDX_IND && pwdata[0])
    |=> ind_q[IND_TRIB_LO])
    else $error("indication lost without a clearing write");
  a_ind_latch: assert property ( // see R13
    ce && $changed(demux_alarm[2]) && !alm_mask_q[2]
    |=> ind_q[IND_DEMUX_LSB + 2] [*2])
    else $error("unmasked alarm change not latched");
  a_ind_masked: assert property ( // see R18
    ce && !ind_q[IND_TRIB_HI] && (los_mask_hi_q == 8'hFF)
    && !(wr_en && idx == IDX_LOS_MASK_HI) |=> !ind_q[IND_TRIB_HI])
    else $error("masked loss alarm set indication");
  a_ind_summary: assert property ( // see R14
    s_rd_setup(IDX_IND) |=> prdata[IND_SUM] == $past(|ind_q))
    else $error("summary bit disagrees with indications");
  a_irq_clear: assert property ( // see R19
    ce && ind_d == '0 |=> !irq)
    else $error("interrupt stayed high with nothing latched");
endmodule

// ---- sim/lbir_line_model.sv ----
`timescale 1ns/1ps
module lbir_line_model
  import lbir_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Gapped clock returned by the block
  input wire logic [N_MUX-1:0] demux_gapped_clock_out,
  // Tributary samples
  output logic [N_TRIB-1:0] trib_line_rx_d,
  output logic [N_TRIB-1:0] trib_drop_d,
  // Second-order samples
  output logic [N_MUX-1:0] low_mux_tx_d,
  output logic [N_MUX-1:0] low_mux_tx_clk,
  output logic [N_MUX-1:0] low_rx_d,
  output logic [N_MUX-1:0] low_rx_clk,
  output logic [N_MUX-1:0] hi_demux_d,
  output logic [N_MUX-1:0] hi_demux_clk,
  output logic [N_MUX-1:0] demux_receive_clock_in,
  output logic [N_MUX-1:0] hi_tx_d,
  output logic [N_MUX-1:0] hi_tx_clk,
  // Third-order samples
  output logic line_rx_d,
  output logic line_rx_clk,
  output logic e3_mux_d,
  output logic e3_mux_clk
);
  logic [31:0] s_q;
  logic [N_MUX-1:0] dj_q;

  // Shifting pattern so every pass-through path sees changing bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= 32'h00000001;
    else
      s_q <= {s_q[30:0], s_q[31] ^ s_q[21] ^ s_q[1] ^ s_q[0]};
  end

  // One flop stands in for the board smoothing loop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dj_q <= 4'h0;
    else
      dj_q <= demux_gapped_clock_out;
  end

  assign demux_receive_clock_in = dj_q;
  assign trib_line_rx_d = s_q[15:0];
  assign trib_drop_d = s_q[31:16];
  assign {low_mux_tx_d, low_rx_d, hi_demux_d, hi_tx_d} = s_q[26:11];
  assign {low_mux_tx_clk, low_rx_clk} = s_q[7:0] ^ s_q[31:24];
  assign {hi_demux_clk, hi_tx_clk} = ~s_q[19:12];
  assign {line_rx_d, line_rx_clk, e3_mux_d, e3_mux_clk} = s_q[30:27];
endmodule

// ---- sim/lbir_regs_tb.sv ----
`timescale 1ns/1ps
module lbir_regs_tb
  import lbir_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ce = 1'b1;
  logic pready, pslverr, irq, err_seen;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd_val;
  logic [N_TRIB-1:0] trib_line_rx_d, trib_drop_d, trib_line_tx_d, trib_add_d;
  logic [N_TRIB-1:0] tributary_signal_loss_flag;
  logic [N_MUX-1:0] low_mux_tx_d, low_mux_tx_clk, low_rx_d, low_rx_clk;
  logic [N_MUX-1:0] low_tx_d, low_tx_clk, low_demux_d, hi_demux_d;
  logic [N_MUX-1:0] hi_demux_clk, demux_receive_clock_in, hi_tx_d, hi_tx_clk;
  logic [N_MUX-1:0] hi_mux_d, hi_mux_clk, hi_rx_d, demux_gapped_clock_out;
  logic [N_MUX-1:0] demux_alarm, hr;
  logic line_rx_d, line_rx_clk, e3_mux_d, e3_mux_clk, line_tx_d, line_tx_clk;
  logic e3_demux_d, e3_demux_clk, line_alarm;
  logic [REG_W-1:0] low_ber_threshold, hi_ber_threshold, lo;
  logic [15:0] tl;
  logic [1:0] ln;
  logic [20:0] alm = 21'h000000;
  logic [63:0] exp_v, obs;
  int bad_count = 0;
  int n_compared = 0;
  // Map order, reset value, readable bits
  logic [IDX_W-1:0] ix [12] = '{IDX_IND, IDX_TRIB_LO, IDX_TRIB_HI,
    IDX_LOW_LOOP, IDX_HI_LOOP, IDX_LINE_LOOP, IDX_LO_BER, IDX_HI_BER,
    IDX_IND_MASK, IDX_LOS_MASK_LO, IDX_LOS_MASK_HI, IDX_ALM_MASK};
  logic [7:0] rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h63,
    8'hDF, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wm [12] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h03, 8'hFF,
    8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h1F};
  // Loop set-ups packed as tributary, low mux, high mux, line fields
  logic [29:0] cf [8] = '{30'h20200000, 30'h00002000, 30'h00004040,
    30'h00000020, 30'h00000002, 30'h00000001, 30'h00000003, 30'h3FFFFFFF};
  int pos [7] = '{0, 8, 16, 17, 18, 19, 20};

  assign {line_alarm, demux_alarm, tributary_signal_loss_flag} = alm;
  assign obs = {trib_line_tx_d, trib_add_d, low_tx_d, low_tx_clk, low_demux_d,
    hi_mux_d, hi_mux_clk, hi_rx_d, demux_gapped_clock_out, line_tx_d,
    line_tx_clk, e3_demux_d, e3_demux_clk};

  lbir_regs u_lbir_regs (.pclk, .presetn, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .tributary_signal_loss_flag, .demux_alarm, .line_alarm,
    .trib_line_rx_d, .trib_drop_d, .trib_line_tx_d, .trib_add_d,
    .low_mux_tx_d, .low_mux_tx_clk, .low_rx_d, .low_rx_clk, .low_tx_d,
    .low_tx_clk, .low_demux_d, .hi_demux_d, .hi_demux_clk,
    .demux_receive_clock_in, .hi_tx_d, .hi_tx_clk, .hi_mux_d, .hi_mux_clk,
    .hi_rx_d, .demux_gapped_clock_out, .line_rx_d, .line_rx_clk, .e3_mux_d,
    .e3_mux_clk, .line_tx_d, .line_tx_clk, .e3_demux_d, .e3_demux_clk,
    .low_ber_threshold, .hi_ber_threshold);

  lbir_line_model u_lbir_line_model (.pclk, .presetn, .demux_gapped_clock_out,
    .trib_line_rx_d, .trib_drop_d, .low_mux_tx_d, .low_mux_tx_clk, .low_rx_d,
    .low_rx_clk, .hi_demux_d, .hi_demux_clk, .demux_receive_clock_in,
    .hi_tx_d, .hi_tx_clk, .line_rx_d, .line_rx_clk, .e3_mux_d, .e3_mux_clk);

  always #4 pclk = ~pclk;

  task report_and_stop;
  begin
    if (bad_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask

  task chk(input string nm, input logic [63:0] seen, input logic [63:0] e);
  begin
    n_compared++;
    if (seen !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, seen);
    end
  end
  endtask

  function automatic logic [7:0] ba(input logic [IDX_W-1:0] i);
    return {i, 2'b00};
  endfunction

  // Held until pready is sampled high; no wait count assumed
  task apb(input logic [7:0] a, input logic w, input logic [7:0] d);
  begin
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_val = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  task rdc(input logic [7:0] a, input logic [7:0] e);
  begin
    apb(a, 1'b0, 8'h00);
    chk($sformatf("reg %h", a), rd_val, {24'h000000, e});
  end
  endtask

  // Two edges: the output flop trails the mask or indication
  task irqc(input logic e);
  begin
    repeat (2) @(negedge pclk);
    chk("irq", irq, e);
  end
  endtask

  function automatic logic [63:0] model();
    logic [15:0] l16;
    l16 = {{4{lo[3]}}, {4{lo[2]}}, {4{lo[1]}}, {4{lo[0]}}};
    return {tl & trib_line_rx_d | ~tl & (l16 | trib_drop_d),
      tl | trib_line_rx_d,
      lo[3:0] & low_rx_d | ~lo[3:0] & (lo[7:4] | low_mux_tx_d),
      lo[3:0] & low_rx_clk | ~lo[3:0] & low_mux_tx_clk,
      lo[7:4] & low_mux_tx_d | ~lo[7:4] & low_rx_d,
      hr & hi_demux_d | ~hr & hi_tx_d,
      hr & demux_receive_clock_in | ~hr & hi_tx_clk,
      hr | hi_demux_d, hi_demux_clk,
      ln[1] ? line_rx_d : ln[0] | e3_mux_d,
      ln[1] ? line_rx_clk : e3_mux_clk,
      ln[1] | (ln[0] ? e3_mux_d : line_rx_d),
      ln == 2'b01 ? e3_mux_clk : line_rx_clk};
  endfunction

  initial
  begin
    #200000;
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk("ber", {low_ber_threshold, hi_ber_threshold}, 16'h63DF);
    for (int i = 0; i < 12; i++)
      rdc(ba(ix[i]), rv[i]);
    for (int i = 0; i < 12; i++)
    begin
      apb(ba(ix[i]), 1'b1, 8'hFF);
      rdc(ba(ix[i]), wm[i]);
      apb(ba(ix[i]), 1'b1, rv[i]);
    end
    apb(ba(IDX_LO_BER), 1'b1, 8'h09);
    apb(ba(IDX_HI_BER), 1'b1, 8'h15);
    @(negedge pclk);
    chk("ber", {low_ber_threshold, hi_ber_threshold}, 16'h0915);
    apb(8'h00, 1'b0, 8'h00);
    chk("unmapped", {err_seen, rd_val}, 33'h100000000);
    apb(8'h31, 1'b1, 8'hFF);
    chk("misaligned", err_seen, 1'b1);
    rdc(ba(IDX_TRIB_LO), 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      {tl, lo, hr, ln} = cf[i];
      apb(ba(IDX_TRIB_LO), 1'b1, tl[7:0]);
      apb(ba(IDX_TRIB_HI), 1'b1, tl[15:8]);
      apb(ba(IDX_LOW_LOOP), 1'b1, lo);
      apb(ba(IDX_HI_LOOP), 1'b1, {4'h0, hr});
      apb(ba(IDX_LINE_LOOP), 1'b1, {6'h00, ln});
      repeat (6)
      begin
        @(negedge pclk);
        exp_v = model();
        @(negedge pclk);
        chk("streams", obs, exp_v);
      end
    end
    // Each source toggled twice, so both directions must latch
    for (int i = 0; i < 7; i++)
      repeat (2)
      begin
        @(posedge pclk);
        alm <= alm ^ (21'h000001 << pos[i]);
        rdc(ba(IDX_IND), 8'h80 | (8'h01 << i));
        irqc(1'b1);
        apb(ba(IDX_IND), 1'b1, 8'h7F ^ (8'h01 << i));
        rdc(ba(IDX_IND), 8'h80 | (8'h01 << i));
        apb(ba(IDX_IND), 1'b1, 8'h01 << i);
        rdc(ba(IDX_IND), 8'h00);
        irqc(1'b0);
      end
    apb(ba(IDX_LOS_MASK_LO), 1'b1, 8'h01);
    apb(ba(IDX_ALM_MASK), 1'b1, 8'h10);
    apb(ba(IDX_IND_MASK), 1'b1, 8'h04);
    @(posedge pclk);
    alm <= alm ^ 21'h110001;
    rdc(ba(IDX_IND), 8'h84);
    irqc(1'b0);
    apb(ba(IDX_IND_MASK), 1'b1, 8'h00);
    irqc(1'b1);
    apb(ba(IDX_IND), 1'b1, 8'h04);
    irqc(1'b0);
    // Enable low: no ready, and an alarm edge waits for the enable
    @(posedge pclk);
    ce <= 1'b0;
    alm <= alm ^ 21'h000100;
    irqc(1'b0);
    chk("pready", pready, 1'b0);
    @(posedge pclk);
    ce <= 1'b1;
    rdc(ba(IDX_IND), 8'h82);
    irqc(1'b1);
    report_and_stop();
  end
endmodule
